// ==== verilog/ext_port_pkg.sv ====
// constants and types for the external memory port pin logic
// assumes one clock domain and a synchronous active-low reset
package ext_port_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 24;
    localparam int SEL_N = 4;
    localparam int WAIT_W = 4;
    // position of the priority-off control in the operating mode word
    localparam int PRIORITY_OFF_BIT = 14;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RESET = 24'h000000;
    localparam logic [SEL_N-1:0] SEL_NONE = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_NONE = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_STEP = 4'h1;

    typedef enum logic [0:0] {st_idle, st_access} bus_state_t;
endpackage

// ==== verilog/region_select_encode.sv ====
// attribute / row strobe line encoder, purely combinational
// assumes the caller registers the result before it reaches a pin
module region_select_encode #(
    parameter int SEL_N = ext_port_pkg::SEL_N
) (
    // request
    input wire logic [SEL_N-1:0] request,
    input wire logic enable,
    // configuration
    input wire logic priority_off,
    input wire logic row_mode,
    input wire logic [SEL_N-1:0] polarity,
    // result, pin levels
    output logic [SEL_N-1:0] lines
);
    wire [SEL_N-1:0] gated = enable ? request : '0;
    // lowest requested line wins, so at most one is asserted
    wire [SEL_N-1:0] lowest = gated & (~gated + SEL_N'(1));
    // with priority off the raw code goes out for outside decoding
    wire [SEL_N-1:0] attr_lines = priority_off ? gated : lowest;
    // row strobes take their active level from the polarity bits
    wire [SEL_N-1:0] row_lines = ~(gated ^ polarity);

    assign lines = row_mode ? row_lines : attr_lines;
endmodule

// ==== verilog/ext_mem_port.sv ====
// external memory port pin logic: address, data, attribute lines, strobes
// assumes a core request port on one side and pad cells that resolve
// each pin from its output enable on the other; ack is synchronous
// How it works
// - standby floats every port pin
// - drive address only while owning bus
// - address holds value between external accesses
// - data driven only in owned write cycles
// - priority off passes all four lines
// - row strobe polarity set by configuration
// - read strobe low during owned reads
// - write strobe low during owned writes
// - cycle ends one clock after ack
// - no stretch at zero wait or rows
module ext_mem_port #(
    parameter int ADDR_W = ext_port_pkg::ADDR_W,
    parameter int DATA_W = ext_port_pkg::DATA_W,
    parameter int SEL_N = ext_port_pkg::SEL_N,
    parameter int WAIT_W = ext_port_pkg::WAIT_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // core request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [SEL_N-1:0] req_region,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    // control
    input wire logic bus_owned,
    input wire logic low_power,
    input wire logic select_priority_off,
    input wire logic row_strobe_mode,
    input wire logic [SEL_N-1:0] row_strobe_polarity,
    input wire logic [WAIT_W-1:0] bus_wait_config,
    // address pins
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe,
    // data pins
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    // attribute / row strobe pins
    output logic [SEL_N-1:0] region_select_lines,
    output logic region_select_oe,
    // strobes
    output logic rd_n,
    output logic rd_oe,
    output logic wr_n,
    output logic wr_oe,
    output logic bus_busy_n,
    output logic bus_busy_oe,
    output logic col_strobe_n,
    output logic col_strobe_oe,
    // transfer acknowledge
    input wire logic cycle_done_ack_n
);
    ext_port_pkg::bus_state_t state;
    ext_port_pkg::bus_state_t next_state;
    logic [WAIT_W-1:0] wait_count;
    logic [WAIT_W-1:0] next_wait_count;
    logic cyc_write;
    logic cyc_stretch;
    logic cfg_row;
    logic cfg_prio_off;
    logic [SEL_N-1:0] cfg_pol;
    logic [SEL_N-1:0] cyc_region;
    logic [SEL_N-1:0] next_sel;

    // standby drops ownership at once, not at the end of the cycle
    wire owned = bus_owned & ~low_power;
    wire start = (state == ext_port_pkg::st_idle) & req_valid & owned;
    // ack stretching needs programmed waits and is never used on rows
    wire stretch_ok = (bus_wait_config != ext_port_pkg::WAIT_NONE) & ~row_strobe_mode;
    wire count_zero = (wait_count == ext_port_pkg::WAIT_NONE);
    wire ack_hold = cyc_stretch & cycle_done_ack_n;
    wire finish = (state == ext_port_pkg::st_access) & count_zero & ~ack_hold & owned;
    wire in_cycle = (next_state == ext_port_pkg::st_access);
    // a starting cycle shows its own request and config on the lines at once
    wire [SEL_N-1:0] sel_request = start ? req_region : cyc_region;
    wire sel_prio_off = start ? select_priority_off : cfg_prio_off;
    wire sel_row = start ? row_strobe_mode : cfg_row;
    wire [SEL_N-1:0] sel_pol = start ? row_strobe_polarity : cfg_pol;

    always_comb begin
        next_state = state;
        next_wait_count = wait_count;
        unique case (state)
            ext_port_pkg::st_idle: begin
                if (start) begin
                    next_state = ext_port_pkg::st_access;
                    next_wait_count = bus_wait_config;
                end
            end
            ext_port_pkg::st_access: begin
                if (!owned || finish) begin
                    next_state = ext_port_pkg::st_idle;
                end else if (!count_zero) begin
                    next_wait_count = wait_count - WAIT_W'(ext_port_pkg::WAIT_STEP);
                end
            end
        endcase
    end

    region_select_encode #(.SEL_N(SEL_N)) u_sel (
        .request(sel_request),
        .enable(in_cycle),
        .priority_off(sel_prio_off),
        .row_mode(sel_row),
        .polarity(sel_pol),
        .lines(next_sel)
    );

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= ext_port_pkg::st_idle;
            wait_count <= ext_port_pkg::WAIT_NONE;
            cyc_write <= 1'b0;
            cyc_stretch <= 1'b0;
            cfg_row <= 1'b0;
            cfg_prio_off <= 1'b0;
            cfg_pol <= ext_port_pkg::SEL_NONE;
            cyc_region <= ext_port_pkg::SEL_NONE;
        end else begin
            state <= next_state;
            wait_count <= next_wait_count;
            if (start) begin
                cyc_write <= req_write;
                cyc_stretch <= stretch_ok;
                cfg_row <= row_strobe_mode;
                cfg_prio_off <= select_priority_off;
                cfg_pol <= row_strobe_polarity;
                cyc_region <= req_region;
            end
        end
    end

    // address latches only at a cycle start, so idle pins never toggle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            addr_out <= ext_port_pkg::ADDR_RESET;
            data_out <= ext_port_pkg::DATA_RESET;
        end else if (start) begin
            addr_out <= req_addr;
            data_out <= req_wdata;
        end
    end

    // pad enables follow ownership one clock later; data_oe also needs an owned write cycle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            addr_oe <= 1'b0;
            data_oe <= 1'b0;
            region_select_oe <= 1'b0;
            rd_oe <= 1'b0;
            wr_oe <= 1'b0;
            bus_busy_oe <= 1'b0;
            col_strobe_oe <= 1'b0;
        end else begin
            addr_oe <= owned;
            data_oe <= owned & in_cycle & (start ? req_write : cyc_write);
            region_select_oe <= owned;
            rd_oe <= owned;
            wr_oe <= owned;
            bus_busy_oe <= owned;
            col_strobe_oe <= owned;
        end
    end

    wire next_write = start ? req_write : cyc_write;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            bus_busy_n <= 1'b1;
            col_strobe_n <= 1'b1;
            region_select_lines <= ext_port_pkg::SEL_NONE;
        end else begin
            rd_n <= ~(owned & in_cycle & ~next_write);
            wr_n <= ~(owned & in_cycle & next_write);
            bus_busy_n <= ~owned;
            // column strobe timing is not generated here; it idles inactive
            col_strobe_n <= 1'b1;
            region_select_lines <= next_sel;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= ext_port_pkg::DATA_RESET;
        end else begin
            busy <= in_cycle;
            done <= finish;
            if (finish && !cyc_write) begin
                rdata <= data_in;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    standby_float_a: assert property (low_power |=> !addr_oe && !data_oe && !rd_oe && !wr_oe
        && !region_select_oe && !bus_busy_oe && !col_strobe_oe)
        else $error("port pins still driven in standby");
    addr_float_a: assert property (!bus_owned |=> !addr_oe)
        else $error("address driven without ownership");
    addr_hold_a: assert property (!start |=> $stable(addr_out))
        else $error("address changed outside a cycle start");
    data_drive_a: assert property (data_oe |-> !wr_n && wr_oe && rd_n)
        else $error("data driven outside an owned write");
    one_hot_sel_a: assert property (!cfg_row && !cfg_prio_off |-> $onehot0(region_select_lines))
        else $error("more than one select line asserted");
    prio_pass_a: assert property (start && !row_strobe_mode && select_priority_off
        ##1 busy |-> region_select_lines == cyc_region)
        else $error("priority off did not pass request code");
    row_polarity_a: assert property (state == ext_port_pkg::st_idle && cfg_row
        && $past(state) == ext_port_pkg::st_idle |-> region_select_lines == ~cfg_pol)
        else $error("idle row strobes not at inactive level");
    read_strobe_a: assert property (!rd_n |-> rd_oe && !cyc_write && busy)
        else $error("read strobe outside an owned read");
    write_strobe_a: assert property (!wr_n |-> wr_oe && cyc_write && busy)
        else $error("write strobe outside an owned write");
    ack_finish_a: assert property (state == ext_port_pkg::st_access && count_zero
        && cyc_stretch && !cycle_done_ack_n && owned |=> done && rd_n && wr_n)
        else $error("cycle did not end one clock after ack");
    zero_wait_a: assert property (start && bus_wait_config == ext_port_pkg::WAIT_NONE
        ##1 owned |=> done)
        else $error("zero wait access was stretched");

    read_cycle_c: cover property (start && !req_write ##[1:20] done);
    write_cycle_c: cover property (start && req_write ##[1:20] done);
    stretched_c: cover property (ack_hold ##1 ack_hold ##[1:10] done);
    standby_abort_c: cover property (busy && low_power);
endmodule

// ==== testbench/ext_mem_model.sv ====
// external memory and acknowledge source on the far side of the port
// assumes pins are resolved here from the port's output enables
module ext_mem_model (
    // clock
    input wire logic clock,
    // port pins
    input wire logic [17:0] addr_out,
    input wire logic [23:0] data_out,
    input wire logic data_oe,
    input wire logic rd_n,
    input wire logic rd_oe,
    input wire logic wr_n,
    input wire logic wr_oe,
    // bench control: strobe cycles before ack goes low
    input wire logic [3:0] ack_delay,
    // to the port
    output logic [23:0] data_in,
    output logic cycle_done_ack_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem [16];
    logic [23:0] last = 24'h000000;
    logic [3:0] cnt = 4'h0;
    wire rd_on = rd_oe && rd_n == 1'b0;
    wire wr_on = wr_oe && wr_n == 1'b0;
    // released lines show the inverse of the last level, never a stale copy
    assign data_in = data_oe ? data_out : (rd_on ? mem[addr_out[3:0]] : ~last);
    // ack held high for ack_delay strobe cycles to stretch the cycle
    assign cycle_done_ack_n = !((rd_on || wr_on) && cnt >= ack_delay);
    always @(posedge clock) begin
        last <= data_in;
        cnt <= (rd_on || wr_on) ? cnt + 4'h1 : 4'h0;
        if (wr_on && data_oe)
            mem[addr_out[3:0]] <= data_out;
    end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the external memory port pin logic
// assumes ext_mem_model on the pins; inputs change at falling edges
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [17:0] req_addr = 18'h00000, addr_out, s_addr;
    logic [23:0] req_wdata = 24'h000000, rdata, data_in, data_out;
    logic [3:0] req_region = 4'h0, row_strobe_polarity = 4'h0, region_select_lines, s_lines;
    logic [3:0] bus_wait_config = 4'h0, ack_delay = 4'h0;
    logic bus_owned = 1'b1, low_power = 1'b0, select_priority_off = 1'b0;
    logic row_strobe_mode = 1'b0, busy, done, addr_oe, data_oe, region_select_oe, s_strb, s_doe;
    logic rd_n, rd_oe, wr_n, wr_oe, bus_busy_n, bus_busy_oe, col_strobe_n, col_strobe_oe;
    logic cycle_done_ack_n;
    int fail_count = 0, total_checks = 0, cycles = 0, n;
    ext_mem_port ext_mem_port_i (.clock, .nrst, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_region, .busy, .done, .rdata, .bus_owned, .low_power, .select_priority_off,
        .row_strobe_mode, .row_strobe_polarity, .bus_wait_config, .addr_out, .addr_oe,
        .data_in, .data_out, .data_oe, .region_select_lines, .region_select_oe, .rd_n, .rd_oe,
        .wr_n, .wr_oe, .bus_busy_n, .bus_busy_oe, .col_strobe_n, .col_strobe_oe,
        .cycle_done_ack_n);
    ext_mem_model ext_mem_model_i (.clock, .addr_out, .data_out, .data_oe, .rd_n, .rd_oe,
        .wr_n, .wr_oe, .ack_delay, .data_in, .cycle_done_ack_n);
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // entered at a falling edge; one idle clock passes before the request rises
    task automatic access(input logic wr, input logic [17:0] a, input logic [23:0] d,
        input logic [3:0] rg, input logic [3:0] w, output int k);
        @(negedge clock);
        req_write = wr; req_addr = a; req_wdata = d; req_region = rg;
        bus_wait_config = w; req_valid = 1'b1; k = 0;
        do begin
            @(posedge clock); #1; k++;
            if (k == 1) begin
                s_lines = region_select_lines; s_addr = addr_out;
                s_strb = wr ? wr_n : rd_n; s_doe = data_oe;
            end
        end while (done !== 1'b1 && k < 40);
        @(negedge clock); req_valid = 1'b0;
    endtask
    task automatic t_rw();
        access(1'b1, 18'h2a5a5, 24'h123456, 4'h2, 4'h0, n);
        check(n, 2);
        check(s_strb, 1'b0);
        check(s_doe, 1'b1);
        check(s_addr, 18'h2a5a5);
        check(s_lines, 4'h2);
        check(data_out, 24'h123456);
        access(1'b0, 18'h2a5a5, 24'h000000, 4'h0, 4'h1, n);
        check(n, 3);
        check({s_strb, s_doe}, 2'b00);
        check(rdata, 24'h123456);
        repeat (5) @(negedge clock);
        check(addr_out, 18'h2a5a5);
        $display("test rw done");
    endtask
    task automatic t_sel();
        access(1'b0, 18'h00001, 24'h000000, 4'hf, 4'h0, n);
        check(s_lines, 4'h1);
        select_priority_off = 1'b1;
        access(1'b0, 18'h00002, 24'h000000, 4'hf, 4'h0, n);
        check(s_lines, 4'hf);
        select_priority_off = 1'b0;
        row_strobe_mode = 1'b1; row_strobe_polarity = 4'h5;
        access(1'b0, 18'h00003, 24'h000000, 4'h3, 4'h0, n);
        check(s_lines, 4'h9);
        @(negedge clock);
        check(region_select_lines, 4'ha);
        $display("test select done");
    endtask
    task automatic t_stretch();
        ack_delay = 4'h5;
        access(1'b0, 18'h00004, 24'h000000, 4'h0, 4'h2, n);
        check(n, 4);
        row_strobe_mode = 1'b0;
        access(1'b0, 18'h00004, 24'h000000, 4'h0, 4'h0, n);
        check(n, 2);
        access(1'b1, 18'h00005, 24'h00abcd, 4'h0, 4'h2, n);
        check(n, 7);
        ack_delay = 4'h0;
        $display("test stretch done");
    endtask
    task automatic t_release();
        low_power = 1'b1;
        repeat (2) @(negedge clock);
        check({addr_oe, data_oe, region_select_oe, rd_oe, wr_oe, bus_busy_oe,
            col_strobe_oe}, 7'h00);
        low_power = 1'b0; bus_owned = 1'b0; req_valid = 1'b1;
        repeat (3) @(negedge clock);
        check({busy, addr_oe, rd_oe, wr_oe}, 4'h0);
        req_valid = 1'b0; bus_owned = 1'b1;
        repeat (2) @(negedge clock);
        check({bus_busy_n, addr_oe, rd_oe, wr_oe, col_strobe_n, col_strobe_oe}, 6'h1f);
        $display("test release done");
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (10) @(negedge clock);
        check({addr_oe, rd_n, wr_n}, 3'b011);
        nrst = 1'b1;
        @(negedge clock);
        check({addr_oe, rd_n, wr_n}, 3'b111);
        t_rw();
        t_sel();
        t_stretch();
        t_release();
        tally_and_finish();
    end
endmodule
